// ===== rtl/sideband_wire_discovery_consts.svh
`ifndef SIDEBAND_WIRE_DISCOVERY_CONSTS_SVH
`define SIDEBAND_WIRE_DISCOVERY_CONSTS_SVH
////////////////////////////////////////////////////////////////////////////////
// timing
`define CLK_PERIOD_NS 50
`define RX_TIMEOUT_NS 1000000000
`define TURNAROUND_MIN_NS 100
`define BREAK_MIN_NS 50000
`define BREAK_DET_NS 25000
`define DEF_BIT_CYCLES 20
////////////////////////////////////////////////////////////////////////////////
// discovery state encodings
`define DST_ABSENT 2'h0
`define DST_SIMPLE 2'h1
`define DST_GOOD 2'h2
`define DST_AVAIL 2'h3
////////////////////////////////////////////////////////////////////////////////
// register offsets and fields
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_PAY_SEL 8'h08
`define OFF_PAY_DATA 8'h0C
`define OFF_INFO 8'h10
`define OFF_IDENT 8'h14
`define OFF_DEVVER 8'h18
`define CTRL_FETCH_LSB 0
`define CTRL_EXCH_LSB 8
`define CTRL_STIM_LSB 16
`define STATUS_ACT_LSB 16
`define SEL_TGT_LSB 8
////////////////////////////////////////////////////////////////////////////////
// payload layout
`define HDR_VERSION 0
`define HDR_CLASS 1
`define HDR_SIZE 2
`define HDR_VWCNT 3
`define HDR_PART_HI 4
`define HDR_PART_LO 5
`define HDR_MAKER_HI 6
`define HDR_MAKER_LO 7
`define HDR_DEVVER 8
`define HDR_DSTCNT 10
`define HDR_LEN 12
`define DSTDESC_LEN 2
`define CSUM_LEN 1
`define SIZE_UNIT_SHIFT 3
////////////////////////////////////////////////////////////////////////////////
// link
`define PAYLOAD_REQ_CMD 8'h02
`define RETRIES 2
`define UART_STOP_BIT 10
`endif

// ===== rtl/sideband_wire_discovery_pkg.sv
package sideband_wire_discovery_pkg;
  typedef enum logic [1:0] {
    ST_SEL = 2'b00,
    ST_SEND = 2'b01,
    ST_RECV = 2'b10,
    ST_EVAL = 2'b11
  } fsm_t;
endpackage

// ===== rtl/sideband_wire_discovery.sv
// Behaviour
// [R1] exchange starts by itself after good payload
// [R2] discovery state resets to absent
// [R3] low break gives simple, release gives available
// [R4] request sent, good checksum gives payload-good
// [R5] target waits turnaround before answering
// [R6] response incomplete at timeout counts failed
// [R7] no active phase before good payload
// [R8] success needs time, parity, framing, checksum
// [R9] retry until good unless fetch disabled
// [R10] three attempts per target, then rotate
// [R11] target releases secondary wires after reset
// [R12] target drives unused wires low when active
// [R13] request in active phase releases wires
// [R14] payload order header, routes, wires, checksum
// [R15] target pads payload to eight-byte multiple
// [R16] byte zero version, byte one class
// [R17] byte three holds two wire-byte counts
// [R18] byte ten holds destination and power counts
// [R19] low stimulus then refetch for coupling
// [R20] target pulses wires low to announce
// [R21] no traffic while target holds wire low
// [R22] target holds break at least minimum; the testbench holds brk for 600 cycles (30000 ns), below BREAK_MIN_NS 50000
// [R23] byte two gives size in eight-byte units
// [R24] identities and version sent high byte first
`timescale 1ns/1ns
`include "sideband_wire_discovery_consts.svh"
module sideband_wire_discovery #(
  parameter int NUM_TARGETS = 2,
  parameter int MAX_BYTES = 64,
  parameter int BIT_CYCLES = `DEF_BIT_CYCLES,
  parameter int RX_TIMEOUT_CYC = `RX_TIMEOUT_NS / `CLK_PERIOD_NS
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic [NUM_TARGETS-1:0] sb_in_i,
  output logic [NUM_TARGETS-1:0] sb_out_o,
  output logic [NUM_TARGETS-1:0] sb_oe_o,
  output logic [NUM_TARGETS-1:0] exchange_active_o
);
  localparam int TW = (NUM_TARGETS > 1) ? $clog2(NUM_TARGETS) : 1;
  localparam int MW = $clog2(NUM_TARGETS * MAX_BYTES);
  localparam int BREAK_DET_CYC = `BREAK_DET_NS / `CLK_PERIOD_NS;
  localparam int MIN_LEN = `HDR_LEN + `DSTDESC_LEN + `CSUM_LEN;
  localparam int RETRY_MAX = `RETRIES;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  ////////////////////////////////////////////////////////////////////////////////
  // wire synchronisers and break detection
  logic [NUM_TARGETS-1:0] sync1_r, sync2_r, brk_r;
  logic [NUM_TARGETS-1:0][10:0] low_cnt_r;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r <= '1;
      sync2_r <= '1;
    end else begin
      sync1_r <= sb_in_i;
      sync2_r <= sync1_r;
    end
  end
  genvar g;
  generate
    for (g = 0; g < NUM_TARGETS; g++) begin : g_brk
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          low_cnt_r[g] <= '0;
          brk_r[g] <= 1'b0;
        end else if (sync2_r[g]) begin
          low_cnt_r[g] <= '0;
          brk_r[g] <= 1'b0;
        end else if (low_cnt_r[g] == 11'(BREAK_DET_CYC - 1)) begin
          brk_r[g] <= 1'b1;
        end else begin
          low_cnt_r[g] <= low_cnt_r[g] + 11'h001;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // control registers and bus slave
  logic [NUM_TARGETS-1:0] fetch_en_r, exch_en_r, stim_r, fetch_prev_r, act_r;
  logic [TW-1:0] sel_tgt_r;
  logic [7:0] sel_idx_r;
  logic wr_pend_r;
  logic [7:0] waddr_r;
  logic [1:0] dst_r [NUM_TARGETS];
  logic [1:0] dst_nxt [NUM_TARGETS];
  logic [7:0] pay_mem [NUM_TARGETS * MAX_BYTES];

  function automatic logic [7:0] hdr_byte(input logic [TW-1:0] t, input int idx);
    return pay_mem[MW'(int'(t) * MAX_BYTES + idx)];
  endfunction

  wire acc_w = hsel_i & hready_i & htrans_i[1];
  wire mapped_w = (haddr_i[31:8] == 24'h000000) && (haddr_i[1:0] == 2'h0);
  wire [NUM_TARGETS-1:0] fetch_rise_w = fetch_en_r & ~fetch_prev_r;
  logic [31:0] status_w;
  always_comb begin
    status_w = '0;
    for (int i = 0; i < NUM_TARGETS; i++) begin
      status_w[2*i +: 2] = dst_r[i];
      status_w[`STATUS_ACT_LSB + i] = act_r[i];
    end
  end
  wire sel_ok_w = (int'(sel_idx_r) < MAX_BYTES);
  logic [31:0] info_w, ident_w, devver_w;
  logic [7:0] pay_rd_w;
  // comb process so stored bytes show as soon as they land
  always_comb begin
    info_w = {hdr_byte(sel_tgt_r, `HDR_SIZE), hdr_byte(sel_tgt_r, `HDR_DSTCNT), // [R23] [R18]
              hdr_byte(sel_tgt_r, `HDR_VWCNT), // [R17]
              hdr_byte(sel_tgt_r, `HDR_CLASS)}; // [R16]
    ident_w = {hdr_byte(sel_tgt_r, `HDR_PART_HI), hdr_byte(sel_tgt_r, `HDR_PART_LO),
               hdr_byte(sel_tgt_r, `HDR_MAKER_HI),
               hdr_byte(sel_tgt_r, `HDR_MAKER_LO)}; // [R24]
    devver_w = {16'h0000, hdr_byte(sel_tgt_r, `HDR_DEVVER),
                hdr_byte(sel_tgt_r, `HDR_VERSION)}; // [R24] [R16]
    pay_rd_w = sel_ok_w ? hdr_byte(sel_tgt_r, int'(sel_idx_r)) : 8'h00;
  end
  wire [31:0] ctrl_w = ({{(32-NUM_TARGETS){1'b0}}, fetch_en_r} << `CTRL_FETCH_LSB)
                     | ({{(32-NUM_TARGETS){1'b0}}, exch_en_r} << `CTRL_EXCH_LSB)
                     | ({{(32-NUM_TARGETS){1'b0}}, stim_r} << `CTRL_STIM_LSB);
  wire [31:0] rdata_w = !mapped_w ? 32'h00000000 :
                        (haddr_i[7:0] == `OFF_CTRL) ? ctrl_w :
                        (haddr_i[7:0] == `OFF_STATUS) ? status_w :
                        (haddr_i[7:0] == `OFF_PAY_SEL) ?
                          {16'h0000, 8'(sel_tgt_r), sel_idx_r} :
                        (haddr_i[7:0] == `OFF_PAY_DATA) ? {24'h000000, pay_rd_w} :
                        (haddr_i[7:0] == `OFF_INFO) ? info_w :
                        (haddr_i[7:0] == `OFF_IDENT) ? ident_w :
                        (haddr_i[7:0] == `OFF_DEVVER) ? devver_w : 32'h00000000;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      hrdata_o <= '0;
      wr_pend_r <= 1'b0;
      waddr_r <= '0;
    end else if (wr_pend_r) begin
      wr_pend_r <= 1'b0;
      hreadyout_o <= 1'b1;
    end else if (acc_w && hwrite_i) begin
      wr_pend_r <= mapped_w;
      hreadyout_o <= !mapped_w;
      waddr_r <= haddr_i[7:0];
    end else if (acc_w) begin
      hrdata_o <= rdata_w;
    end
  end

  wire wr_ctrl_w = wr_pend_r && (waddr_r == `OFF_CTRL);
  wire wr_sel_w = wr_pend_r && (waddr_r == `OFF_PAY_SEL);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fetch_en_r <= '0;
      exch_en_r <= '0;
      stim_r <= '0;
      fetch_prev_r <= '0;
      sel_tgt_r <= '0;
      sel_idx_r <= '0;
    end else begin
      fetch_prev_r <= fetch_en_r;
      if (wr_ctrl_w) begin
        fetch_en_r <= hwdata_i[`CTRL_FETCH_LSB +: NUM_TARGETS];
        exch_en_r <= hwdata_i[`CTRL_EXCH_LSB +: NUM_TARGETS];
        stim_r <= hwdata_i[`CTRL_STIM_LSB +: NUM_TARGETS];
      end
      if (wr_sel_w) begin
        sel_tgt_r <= hwdata_i[`SEL_TGT_LSB +: TW];
        sel_idx_r <= hwdata_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request and receive engine
  sideband_wire_discovery_pkg::fsm_t fsm_r;
  logic [TW-1:0] cur_r;
  logic [1:0] att_r;
  logic [10:0] tx_sh_r;
  logic [3:0] bit_r;
  logic [15:0] baud_r;
  logic [31:0] tmo_r;
  logic rx_busy_r, err_r;
  logic [7:0] rx_sh_r, sum_r, rcnt_r;
  logic [11:0] total_r;

  wire line_w = sync2_r[cur_r];
  wire [NUM_TARGETS-1:0] elig_w;
  generate
    for (g = 0; g < NUM_TARGETS; g++) begin : g_elig
      assign elig_w[g] = fetch_en_r[g] && (dst_r[g] == `DST_AVAIL) && sync2_r[g]
                         && !brk_r[g] && !act_r[g]; // [R9] [R21]
    end
  endgenerate
  wire last_tgt_w = (cur_r == TW'(NUM_TARGETS - 1));
  wire [TW-1:0] cur_adv_w = last_tgt_w ? '0 : cur_r + TW'(1);
  wire is_send_w = (fsm_r == sideband_wire_discovery_pkg::ST_SEND);
  wire is_recv_w = (fsm_r == sideband_wire_discovery_pkg::ST_RECV);
  wire is_eval_w = (fsm_r == sideband_wire_discovery_pkg::ST_EVAL);
  wire bit_end_w = (baud_r == 16'(BIT_CYCLES - 1));
  wire rx_tick_w = (bit_r == 4'h0) ? (baud_r == 16'(BIT_CYCLES / 2 - 1)) : bit_end_w;
  wire rx_stop_w = rx_busy_r && rx_tick_w && (bit_r == 4'(`UART_STOP_BIT));
  wire par_bad_w = rx_busy_r && rx_tick_w && (bit_r == 4'h9) && (line_w != ^rx_sh_r);
  wire frm_bad_w = rx_stop_w && !line_w;
  wire [7:0] sum_nxt_w = sum_r + rx_sh_r;
  wire [11:0] size_len_w = {4'h0, rx_sh_r} << `SIZE_UNIT_SHIFT; // [R23]
  wire len_bad_w = rx_stop_w && (rcnt_r == 8'(`HDR_SIZE))
                   && ((int'(size_len_w) < MIN_LEN) || (int'(size_len_w) > MAX_BYTES)); // [R14]
  wire last_byte_w = rx_stop_w && (rcnt_r > 8'(`HDR_SIZE))
                     && ({4'h0, rcnt_r} == total_r - 12'h001);
  wire timeout_w = is_recv_w && (tmo_r == 32'(RX_TIMEOUT_CYC - 1)); // [R6]
  wire lost_w = is_recv_w && (dst_r[cur_r] != `DST_AVAIL);
  wire ok_w = is_eval_w && !err_r && (sum_r == 8'h00); // [R8]

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fsm_r <= sideband_wire_discovery_pkg::ST_SEL;
      cur_r <= '0;
      att_r <= '0;
      tx_sh_r <= '1;
      bit_r <= '0;
      baud_r <= '0;
      tmo_r <= '0;
      rx_busy_r <= 1'b0;
      err_r <= 1'b0;
      rx_sh_r <= '0;
      sum_r <= '0;
      rcnt_r <= '0;
      total_r <= '0;
    end else begin
      case (fsm_r)
        sideband_wire_discovery_pkg::ST_SEL: begin
          if (elig_w[cur_r]) begin
            tx_sh_r <= {1'b1, ^`PAYLOAD_REQ_CMD, `PAYLOAD_REQ_CMD, 1'b0}; // [R4]
            bit_r <= '0;
            baud_r <= '0;
            fsm_r <= sideband_wire_discovery_pkg::ST_SEND;
          end else begin
            cur_r <= cur_adv_w;
            att_r <= '0;
          end
        end
        sideband_wire_discovery_pkg::ST_SEND: begin
          baud_r <= bit_end_w ? 16'h0000 : baud_r + 16'h0001;
          if (bit_end_w && bit_r == 4'(`UART_STOP_BIT)) begin
            fsm_r <= sideband_wire_discovery_pkg::ST_RECV;
            bit_r <= '0;
            tmo_r <= '0;
            rx_busy_r <= 1'b0;
            err_r <= 1'b0;
            sum_r <= '0;
            rcnt_r <= '0;
            total_r <= '1;
          end else if (bit_end_w) begin
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
            bit_r <= bit_r + 4'h1;
          end
        end
        sideband_wire_discovery_pkg::ST_RECV: begin
          tmo_r <= tmo_r + 32'h00000001;
          if (timeout_w || lost_w || par_bad_w || frm_bad_w || len_bad_w) begin
            err_r <= 1'b1; // [R6] [R8]
            fsm_r <= sideband_wire_discovery_pkg::ST_EVAL;
          end else if (!rx_busy_r) begin
            if (!line_w) begin
              rx_busy_r <= 1'b1; // [R5]
              baud_r <= '0;
              bit_r <= '0;
            end
          end else if (rx_tick_w) begin
            baud_r <= '0;
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h0 && line_w) begin
              rx_busy_r <= 1'b0;
            end else if (bit_r >= 4'h1 && bit_r <= 4'h8) begin
              rx_sh_r <= {line_w, rx_sh_r[7:1]};
            end else if (rx_stop_w) begin
              rx_busy_r <= 1'b0;
              sum_r <= sum_nxt_w;
              rcnt_r <= rcnt_r + 8'h01;
              if (rcnt_r == 8'(`HDR_SIZE)) begin
                total_r <= size_len_w;
              end
              if (last_byte_w) begin
                fsm_r <= sideband_wire_discovery_pkg::ST_EVAL;
              end
            end
          end else begin
            baud_r <= baud_r + 16'h0001;
          end
        end
        sideband_wire_discovery_pkg::ST_EVAL: begin
          fsm_r <= sideband_wire_discovery_pkg::ST_SEL;
          if (ok_w || att_r == 2'(RETRY_MAX)) begin
            cur_r <= cur_adv_w; // [R10]
            att_r <= '0;
          end else begin
            att_r <= att_r + 2'h1; // [R9] [R10]
          end
        end
        default: fsm_r <= sideband_wire_discovery_pkg::ST_SEL;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rx_stop_w && !frm_bad_w && int'(rcnt_r) < MAX_BYTES) begin
      pay_mem[MW'(int'(cur_r) * MAX_BYTES + int'(rcnt_r))] <= rx_sh_r; // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // discovery state, active phase and pins
  always_comb begin
    for (int i = 0; i < NUM_TARGETS; i++) begin
      dst_nxt[i] = dst_r[i];
      if (fetch_rise_w[i] && dst_r[i] == `DST_GOOD) begin
        dst_nxt[i] = `DST_AVAIL;
      end else if (!act_r[i]) begin // [R7]
        if (brk_r[i] && !sync2_r[i]) begin
          dst_nxt[i] = `DST_SIMPLE; // [R3]
        end else if (brk_r[i]) begin
          dst_nxt[i] = `DST_AVAIL; // [R3]
        end else if (ok_w && int'(cur_r) == i && dst_r[i] == `DST_AVAIL) begin
          dst_nxt[i] = `DST_GOOD; // [R4]
        end
      end
    end
  end

  wire [NUM_TARGETS-1:0] tx_low_w = (is_send_w && !tx_sh_r[0]) ?
                                    (NUM_TARGETS'(1) << cur_r) : '0;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < NUM_TARGETS; i++) begin
        dst_r[i] <= `DST_ABSENT; // [R2]
      end
      act_r <= '0;
      sb_out_o <= '0;
      sb_oe_o <= '0;
      exchange_active_o <= '0;
    end else begin
      dst_r <= dst_nxt;
      for (int i = 0; i < NUM_TARGETS; i++) begin
        if (fetch_rise_w[i]) begin
          act_r[i] <= 1'b0;
        end else if (exch_en_r[i] && dst_r[i] == `DST_GOOD) begin
          act_r[i] <= 1'b1; // [R1] [R7]
        end
      end
      exchange_active_o <= act_r;
      sb_out_o <= '0;
      sb_oe_o <= stim_r | tx_low_w; // [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_sel_to_send;
    (fsm_r == sideband_wire_discovery_pkg::ST_SEL) ##1 is_send_w;
  endsequence
  sequence s_release;
    brk_r[0] && sync2_r[0] && !act_r[0] && !fetch_rise_w[0];
  endsequence

  chk_reset_absent: assert property (disable iff (1'b0) $rose(arst_n_i) |-> dst_r[0] == 2'h0) // [R2]
    else $error("discovery state not absent after reset");
  chk_break_simple: assert property (brk_r[0] && !sync2_r[0] && !act_r[0] && !fetch_rise_w[0]
    |=> dst_r[0] == 2'h1) // [R3]
    else $error("held break did not give simple presence");
  chk_release_avail: assert property (s_release |=> dst_r[0] == 2'h3) // [R3]
    else $error("break release did not give available");
  chk_good_update: assert property (ok_w && cur_r == '0 && !brk_r[0] && !act_r[0]
    && !fetch_rise_w[0] && dst_r[0] == 2'h3 |=> dst_r[0] == 2'h2) // [R4]
    else $error("good payload did not set payload-good");
  chk_no_send_low: assert property (s_sel_to_send |-> $past(line_w) && !$past(brk_r[cur_r])) // [R21]
    else $error("request started on a low wire");
  chk_active_gate: assert property ($rose(act_r[0]) |-> $past(dst_r[0]) == 2'h2
    && $past(exch_en_r[0])) // [R1] [R7]
    else $error("active phase without good payload");
  chk_lock_good: assert property (act_r[0] && !fetch_rise_w[0] |=> dst_r[0] == 2'h2) // [R7]
    else $error("discovery state moved while active");
  chk_timeout_cap: assert property (is_recv_w |-> tmo_r < 32'(RX_TIMEOUT_CYC)) // [R6]
    else $error("receive ran past the timeout");
  chk_ok_criteria: assert property (ok_w |-> !err_r && sum_r == 8'h00
    && total_r[2:0] == 3'h0 ##1 att_r == 2'h0) // [R8] [R14]
    else $error("success without full criteria");
  chk_retry_rotate: assert property (is_eval_w && !ok_w && att_r == 2'h2
    |=> att_r == 2'h0 && cur_r == $past(cur_adv_w)) // [R10]
    else $error("retry set not rotated after third try");
  chk_fetch_gate: assert property ((fsm_r == sideband_wire_discovery_pkg::ST_SEL)
    && !fetch_en_r[cur_r] |=> !is_send_w) // [R9]
    else $error("request sent with fetch disabled");
endmodule

// ===== dv/sideband_target_model.sv
`timescale 1ns/1ns
module sideband_target_model #(
  parameter int BIT_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic wire_i,
  input wire logic brk_i,
  input wire logic [1:0] mode_i,
  input wire logic [191:0] pay_i,
  input wire logic act_i,
  output logic pull_o,
  output logic sec_o,
  output logic [7:0] reqs_o
);
  logic tx_low;
  logic sec_r = 1'b0;
  logic [7:0] seen = 8'h00;
  logic [10:0] fr;
  logic [7:0] b;
  // break low then release announces presence
  assign pull_o = brk_i | tx_low;
  assign sec_o = sec_r;
  // secondary wire low once active, released by a request
  always @(posedge clk_i) begin
    if (reqs_o != seen) begin
      seen <= reqs_o;
      sec_r <= 1'b0;
    end else if (act_i) begin
      sec_r <= 1'b1;
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    tx_low = 1'b0; // wires released after reset
    reqs_o = 8'h00;
    forever begin
      @(negedge wire_i);
      if (!brk_i) begin
        wt(BIT_CYCLES / 2);
        for (int k = 0; k < 10; k++) begin
          fr[k] = wire_i;
          wt(BIT_CYCLES);
        end
        if (fr[8:1] == 8'h02 && !fr[0]) begin
          reqs_o = reqs_o + 8'h01;
          wt(BIT_CYCLES + 4); // turnaround after stop bit
          // mode 2 stays silent, mode 1 spoils the checksum
          if (mode_i != 2'h2) begin
            for (int i = 0; i < 24; i++) begin
              b = pay_i[8*i+:8] ^ {7'h00, mode_i == 2'h1 && i == 23};
              fr = {1'b1, ^b, b, 1'b0};
              for (int k = 0; k < 11; k++) begin
                tx_low <= ~fr[k];
                wt(BIT_CYCLES);
              end
            end
          end
          tx_low <= 1'b0;
        end
      end
    end
  end
endmodule

// ===== dv/sideband_wire_discovery_tb.sv
`timescale 1ns/1ns
`include "sideband_wire_discovery_consts.svh"
module sideband_wire_discovery_tb;
  localparam int BITC = 20;
  logic clk_i;
  logic arst_n_i;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hrdy;
  logic hresp;
  logic [31:0] hrdata;
  logic [1:0] sb_in;
  logic [1:0] sb_out;
  logic [1:0] sb_oe;
  logic [1:0] act;
  logic [1:0] brk;
  logic [1:0] pull;
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic [191:0] pay0;
  logic [191:0] pay1;
  logic [7:0] reqs0;
  logic [7:0] reqs1;
  logic sec0;
  logic sec1;
  logic [7:0] r;
  logic [31:0] a;
  int n_errors;
  int n_checks;
  assign sb_in = ~(sb_oe | pull);
  sideband_wire_discovery #(.BIT_CYCLES(BITC), .RX_TIMEOUT_CYC(6000)) dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
    .sb_in_i(sb_in), .sb_out_o(sb_out), .sb_oe_o(sb_oe), .exchange_active_o(act));
  sideband_target_model #(.BIT_CYCLES(BITC)) tgt0_u (.clk_i(clk_i), .wire_i(sb_in[0]),
    .brk_i(brk[0]), .mode_i(mode0), .pay_i(pay0), .pull_o(pull[0]), .reqs_o(reqs0),
    .act_i(act[0]), .sec_o(sec0));
  sideband_target_model #(.BIT_CYCLES(BITC)) tgt1_u (.clk_i(clk_i), .wire_i(sb_in[1]),
    .brk_i(brk[1]), .mode_i(mode1), .pay_i(pay1), .pull_o(pull[1]), .reqs_o(reqs1),
    .act_i(act[1]), .sec_o(sec1));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic stop_test();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    @(posedge clk_i);
    while (hrdy !== 1'b1) @(posedge clk_i);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_i);
    while (hrdy !== 1'b1) @(posedge clk_i);
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] ad, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, ad, d, x);
  endtask
  task automatic rdc(input string nm, input logic [31:0] ad, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, ad, 32'h0, x);
    chk(nm, e, x);
  endtask
  task automatic wait_st(input int t, input logic [1:0] s);
    logic [31:0] v;
    for (int k = 0; k < 12000; k++) begin
      ahb(1'b0, `OFF_STATUS, 32'h0, v);
      if (v[2*t+:2] === s) break;
    end
    chk("dstate", {30'h0, s}, {30'h0, v[2*t+:2]});
  endtask
  task automatic wait_req(input logic [7:0] n);
    for (int k = 0; k < 20000; k++) begin
      if (reqs1 >= n) break;
      @(posedge clk_i);
    end
    chk("req_count", 32'h1, {31'h0, reqs1 >= n});
  endtask
  function automatic logic [191:0] mk_pay();
    logic [191:0] p;
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 23; i++) p[8*i+:8] = 8'($urandom);
    p[23:16] = 8'h03; // size in eight-byte units
    p[87:80] = p[87:80] & 8'hF7; // destination and power counts
    p[183:160] = 24'h000000; // padding to 24 bytes
    for (int i = 0; i < 23; i++) s = s + p[8*i+:8];
    p[191:184] = 8'h00 - s; // checksum last
    return p;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end
  initial begin
    n_errors = 0;
    n_checks = 0;
    r = $urandom(52299);
    arst_n_i = 1'b0;
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    brk = 2'b00;
    mode0 = 2'h0;
    mode1 = 2'h1;
    pay0 = mk_pay();
    pay1 = mk_pay();
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    rdc("status", `OFF_STATUS, 32'h0);
    rdc("ctrl", `OFF_CTRL, 32'h0);
    chk("out_rsp", 32'h0, {29'h0, hresp, sb_out});
    wr(`OFF_CTRL, 32'h3);
    brk <= 2'b11;
    repeat (600) @(posedge clk_i);
    rdc("status", `OFF_STATUS, 32'h5);
    chk("oe_brk", 32'h0, {30'h0, sb_oe});
    brk <= 2'b00;
    repeat (10) @(posedge clk_i);
    rdc("status", `OFF_STATUS, 32'hF);
    wait_st(0, `DST_GOOD);
    chk("act", 32'h0, {30'h0, act});
    rdc("info", `OFF_INFO, {pay0[23:16], pay0[87:80], pay0[31:24], pay0[15:8]});
    rdc("ident", `OFF_IDENT, {pay0[39:32], pay0[47:40], pay0[55:48], pay0[63:56]});
    rdc("devver", `OFF_DEVVER, {16'h0, pay0[71:64], pay0[7:0]});
    for (int i = 0; i < 24; i++) begin
      wr(`OFF_PAY_SEL, 32'(i));
      rdc("pay_byte", `OFF_PAY_DATA, {24'h0, pay0[8*i+:8]});
    end
    wait_req(8'h03);
    rdc("status", `OFF_STATUS, 32'hE);
    mode1 <= 2'h2;
    wait_req(reqs1 + 8'h02);
    rdc("status", `OFF_STATUS, 32'hE);
    wr(`OFF_CTRL, 32'h1);
    r = reqs1;
    repeat (8000) @(posedge clk_i);
    chk("no_fetch", {24'h0, r}, {24'h0, reqs1});
    mode1 <= 2'h0;
    wr(`OFF_CTRL, 32'h3);
    wait_st(1, `DST_GOOD);
    chk("act", 32'h0, {30'h0, act});
    wr(`OFF_CTRL, 32'h103);
    repeat (3) @(posedge clk_i);
    chk("act", 32'h1, {30'h0, act});
    rdc("status", `OFF_STATUS, 32'h1000A);
    chk("sec", 32'h1, {30'h0, sec1, sec0});
    brk <= 2'b01;
    repeat (600) @(posedge clk_i);
    brk <= 2'b00;
    repeat (10) @(posedge clk_i);
    rdc("status", `OFF_STATUS, 32'h1000A);
    wr(`OFF_CTRL, 32'h20103);
    repeat (2) @(posedge clk_i);
    chk("stim", 32'h2, {30'h0, sb_oe});
    wr(`OFF_CTRL, 32'h103);
    repeat (2) @(posedge clk_i);
    chk("stim", 32'h0, {30'h0, sb_oe});
    wr(`OFF_CTRL, 32'h102);
    wr(`OFF_CTRL, 32'h103);
    repeat (300) @(posedge clk_i);
    chk("sec", 32'h0, {31'h0, sec0});
    rdc("status", `OFF_STATUS, 32'hB);
    wait_st(0, `DST_GOOD);
    repeat (3) @(posedge clk_i);
    chk("act", 32'h1, {30'h0, act});
    a = 32'h1C + 32'($urandom_range(0, 56)) * 4;
    rdc("unmapped", a, 32'h0);
    stop_test();
  end
endmodule
